// File: rtl/acm_defs.vh
// Register map, field positions, reset values and codes of the clock-mode block
`ifndef ACM_DEFS_VH
`define ACM_DEFS_VH

// Sub-addresses on the two-wire bus
`define ACM_LINE_TO_FRAME_ADDR  8'h37
`define ACM_FRAME_TO_LINE_ADDR  8'h38
`define ACM_FRAME_TO_FIXED_ADDR 8'h39
`define ACM_FIXED_TO_LINE_ADDR  8'h3a
`define ACM_MODE_STATUS_ADDR    8'h3b
`define ACM_PLL_LOOP_CTRL_ADDR  8'h46

// Reset values
`define ACM_LINE_TO_FRAME_RST   8'h7c
`define ACM_FRAME_TO_LINE_RST   8'h3c
`define ACM_FRAME_TO_FIXED_RST  8'hdc
`define ACM_FIXED_TO_LINE_RST   8'h04
`define ACM_PLL_LOOP_CTRL_RST   8'h00

// Fields of the PLL loop control register
`define ACM_FRAME_EC_GAIN_LSB   0
`define ACM_LINE_GAIN_LSB       2
`define ACM_CP_GAIN_BIT         4
`define ACM_GM_GAIN_BIT         5
`define ACM_GAIN_AUTO_BIT       6

// Auto-select field codes (control register 0x09 bits 7:6)
`define ACM_SEL_LINE            2'h0
`define ACM_SEL_FRAME           2'h1
`define ACM_SEL_FIXED           2'h2
`define ACM_SEL_AUTO            2'h3

// Bus slave address (7 bits, low bit from the address select pin)
`define ACM_BUS_ADDR_HI         6'h2a

`endif

// File: rtl/acm_clock_mode.v
// Automatic clock-mode selection with its two-wire register port
//
// Contract
// - Thresholds steer the mode only while auto-select picks automatic.
// - Line-to-frame threshold decides leaving line-lock for frame-lock.
// - Threshold at 0x38 decides return from frame-lock to line-lock.
// - Threshold at 0x39, reset 0xdc, decides frame-lock to fixed.
// - Threshold 0x3a, reset 0x04, decides return from fixed to line-lock.
// - Frame-lock EC gain from PLL bits 1:0: x1, x2, x4, x8.
// - PLL control at 0x46, all bits zero after reset, fully read/write.
// - Line-lock EC gain field: 00 x1, 01 x1/2, 10 x4, 11 x2.
// - Auto loop gain ignores CP/GM bits: x1 line-lock, x2 frame-lock.
`timescale 1ns/1ps
`include "acm_defs.vh"

module acm_clock_mode (
   // Clock and reset
   input  wire       clk,
   input  wire       rst_n,
   // Two-wire control bus (open drain data)
   input  wire       scl,
   input  wire       sda_in,
   output reg        sda_out,
   output reg        sda_oe_n,
   input  wire       addr_sel,
   // Decoder side
   input  wire [1:0] auto_clock_sel,
   input  wire       field_tick,
   input  wire [7:0] lock_metric,
   // Clock mode and loop gains
   output reg  [2:0] clock_mode,
   output reg  [3:0] frame_lock_ec_gain,
   output reg  [3:0] line_lock_loop_gain,
   output reg        cp_gain_high,
   output reg        gm_gain_high
);

   // ***************************************************************
   // Clock modes and bus states (one-hot)
   // ***************************************************************
   localparam [2:0] MODE_LINE  = 3'h1;
   localparam [2:0] MODE_FRAME = 3'h2;
   localparam [2:0] MODE_FIXED = 3'h4;

   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_ADDR = 5'h02;
   localparam [4:0] ST_SUB  = 5'h04;
   localparam [4:0] ST_WR   = 5'h08;
   localparam [4:0] ST_RD   = 5'h10;

   reg  [7:0] line_to_frame_threshold;
   reg  [7:0] frame_to_line_threshold;
   reg  [7:0] frame_to_fixed_threshold;
   reg  [7:0] fixed_to_line_threshold;
   reg  [7:0] pll_loop_control;
   reg  [7:0] prev_metric;

   reg  [4:0] state;
   reg  [3:0] bit_cnt;
   reg  [7:0] shift_in;
   reg  [7:0] shift_out;
   reg  [7:0] sub_addr;
   reg        ack_drive;
   reg        scl_q;
   reg        sda_q;

   // Register read decode, shared by first and following read bytes
   function [7:0] read_reg;
      input [7:0] a;
      begin
         case (a)
            `ACM_LINE_TO_FRAME_ADDR:  read_reg = line_to_frame_threshold;
            `ACM_FRAME_TO_LINE_ADDR:  read_reg = frame_to_line_threshold;
            `ACM_FRAME_TO_FIXED_ADDR: read_reg = frame_to_fixed_threshold;
            `ACM_FIXED_TO_LINE_ADDR:  read_reg = fixed_to_line_threshold;
            `ACM_MODE_STATUS_ADDR:    read_reg = {5'h00, clock_mode};
            `ACM_PLL_LOOP_CTRL_ADDR:  read_reg = pll_loop_control;
            default:                  read_reg = 8'h00;
         endcase
      end
   endfunction

   // Line-lock gain in half units: 1 = x1/2, 2 = x1, 4 = x2, 8 = x4
   function [3:0] line_gain;
      input [1:0] code;
      begin
         case (code)
            2'h0:    line_gain = 4'h2;
            2'h1:    line_gain = 4'h1;
            2'h2:    line_gain = 4'h8;
            default: line_gain = 4'h4;
         endcase
      end
   endfunction

   // ***************************************************************
   // Two-wire bus slave
   // ***************************************************************
   wire scl_rise = scl & ~scl_q;
   wire scl_fall = ~scl & scl_q;
   wire bus_start = scl & scl_q & sda_q & ~sda_in;
   wire bus_stop  = scl & scl_q & ~sda_q & sda_in;
   wire [6:0] my_addr = {`ACM_BUS_ADDR_HI, addr_sel};
   // Read bytes for this and the following address, top bit goes out first
   wire [7:0] rd_now  = read_reg(sub_addr);
   wire [7:0] rd_next = read_reg(sub_addr + 8'h01);

   // Bus edges are found by comparing against last cycle's sample
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda_in;
      end
   end

   // Bit engine: sample on SCL rise, change the data line on SCL fall
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state                    <= ST_IDLE;
         bit_cnt                  <= 4'h0;
         shift_in                 <= 8'h00;
         shift_out                <= 8'h00;
         sub_addr                 <= 8'h00;
         ack_drive                <= 1'b0;
         sda_out                  <= 1'b0;
         sda_oe_n                 <= 1'b1;
         line_to_frame_threshold  <= `ACM_LINE_TO_FRAME_RST;
         frame_to_line_threshold  <= `ACM_FRAME_TO_LINE_RST;
         frame_to_fixed_threshold <= `ACM_FRAME_TO_FIXED_RST;
         fixed_to_line_threshold  <= `ACM_FIXED_TO_LINE_RST;
         pll_loop_control         <= `ACM_PLL_LOOP_CTRL_RST;
      end else if (bus_start) begin
         // A repeated start restarts addressing from any state
         state     <= ST_ADDR;
         bit_cnt   <= 4'h0;
         ack_drive <= 1'b0;
         sda_oe_n  <= 1'b1;
      end else if (bus_stop) begin
         state     <= ST_IDLE;
         ack_drive <= 1'b0;
         sda_oe_n  <= 1'b1;
      end else if (scl_rise && state != ST_IDLE && !ack_drive) begin
         shift_in <= {shift_in[6:0], sda_in};
         bit_cnt  <= bit_cnt + 4'h1;
         // Master not-acknowledge ends a read burst
         if (state == ST_RD && bit_cnt == 4'h8 && sda_in)
            state <= ST_IDLE;
      end else if (scl_fall && state != ST_IDLE) begin
         if (ack_drive) begin
            ack_drive <= 1'b0;
            bit_cnt   <= 4'h0;
            if (state == ST_RD) begin
               shift_out <= rd_now;
               sda_oe_n  <= rd_now[7];
            end else begin
               sda_oe_n  <= 1'b1;
            end
         end else if (state == ST_RD) begin
            if (bit_cnt == 4'h9) begin
               // Master acked: next byte from the following address
               sub_addr  <= sub_addr + 8'h01;
               shift_out <= rd_next;
               sda_oe_n  <= rd_next[7];
               bit_cnt   <= 4'h0;
            end else if (bit_cnt == 4'h8) begin
               sda_oe_n  <= 1'b1;
            end else begin
               shift_out <= {shift_out[6:0], 1'b0};
               sda_oe_n  <= shift_out[6];
            end
         end else if (bit_cnt == 4'h8) begin
            case (state)
               ST_ADDR: begin
                  if (shift_in[7:1] == my_addr) begin
                     ack_drive <= 1'b1;
                     sda_oe_n  <= 1'b0;
                     state     <= shift_in[0] ? ST_RD : ST_SUB;
                  end else begin
                     state     <= ST_IDLE;
                  end
               end
               ST_SUB: begin
                  sub_addr  <= shift_in;
                  ack_drive <= 1'b1;
                  sda_oe_n  <= 1'b0;
                  state     <= ST_WR;
               end
               ST_WR: begin
                  // Unmapped and read-only addresses take the byte silently
                  case (sub_addr)
                     `ACM_LINE_TO_FRAME_ADDR:
                        line_to_frame_threshold  <= shift_in;
                     `ACM_FRAME_TO_LINE_ADDR:
                        frame_to_line_threshold  <= shift_in;
                     `ACM_FRAME_TO_FIXED_ADDR:
                        frame_to_fixed_threshold <= shift_in;
                     `ACM_FIXED_TO_LINE_ADDR:
                        fixed_to_line_threshold  <= shift_in;
                     `ACM_PLL_LOOP_CTRL_ADDR:
                        pll_loop_control         <= shift_in;
                     default: ;
                  endcase
                  sub_addr  <= sub_addr + 8'h01;
                  ack_drive <= 1'b1;
                  sda_oe_n  <= 1'b0;
               end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   // ***************************************************************
   // Clock mode selection
   // ***************************************************************
   // Crossing tests use last field's metric so a metric parked beyond a
   // level does not bounce the mode once software moves the level
   wire up_lf = prev_metric <= line_to_frame_threshold &&
                lock_metric > line_to_frame_threshold;
   wire dn_fl = prev_metric >= frame_to_line_threshold &&
                lock_metric < frame_to_line_threshold;
   wire up_ff = prev_metric <= frame_to_fixed_threshold &&
                lock_metric > frame_to_fixed_threshold;
   wire dn_fx = prev_metric >= fixed_to_line_threshold &&
                lock_metric < fixed_to_line_threshold;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clock_mode  <= MODE_LINE;
         prev_metric <= 8'h00;
      end else if (auto_clock_sel != `ACM_SEL_AUTO) begin
         // Manual selection overrides the thresholds
         case (auto_clock_sel)
            `ACM_SEL_FRAME: clock_mode <= MODE_FRAME;
            `ACM_SEL_FIXED: clock_mode <= MODE_FIXED;
            default:        clock_mode <= MODE_LINE;
         endcase
         if (field_tick)
            prev_metric <= lock_metric;
      end else if (field_tick) begin
         prev_metric <= lock_metric;
         case (clock_mode)
            MODE_LINE:
               if (up_lf) clock_mode <= MODE_FRAME;
            MODE_FRAME:
               if (dn_fl)
                  clock_mode <= MODE_LINE;
               else if (up_ff)
                  clock_mode <= MODE_FIXED;
            MODE_FIXED:
               if (dn_fx) clock_mode <= MODE_LINE;
            default: clock_mode <= MODE_LINE;
         endcase
      end
   end

   // ***************************************************************
   // Loop gains
   // ***************************************************************
   // Gains follow the register and current mode one cycle later
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_lock_ec_gain  <= 4'h1;
         line_lock_loop_gain <= 4'h2;
         cp_gain_high        <= 1'b0;
         gm_gain_high        <= 1'b0;
      end else begin
         frame_lock_ec_gain  <= 4'h1 <<
            pll_loop_control[`ACM_FRAME_EC_GAIN_LSB +: 2];
         line_lock_loop_gain <=
            line_gain(pll_loop_control[`ACM_LINE_GAIN_LSB +: 2]);
         if (pll_loop_control[`ACM_GAIN_AUTO_BIT]) begin
            cp_gain_high <= (clock_mode == MODE_FRAME);
            gm_gain_high <= (clock_mode == MODE_FRAME);
         end else begin
            cp_gain_high <= pll_loop_control[`ACM_CP_GAIN_BIT];
            gm_gain_high <= pll_loop_control[`ACM_GM_GAIN_BIT];
         end
      end
   end

endmodule // acm_clock_mode

// File: bench/acm_clock_mode_checker.sv
// Port-level assertions for the clock-mode block
`timescale 1ns/1ps
module acm_clock_mode_checker (
   // Clock, reset, bus and decoder inputs
   input wire       clk, rst_n, scl, sda_in, sda_out, sda_oe_n, addr_sel,
   input wire [1:0] auto_clock_sel,
   input wire       field_tick,
   input wire [7:0] lock_metric,
   // Mode and gain outputs
   input wire [2:0] clock_mode,
   input wire [3:0] frame_lock_ec_gain,
   input wire [3:0] line_lock_loop_gain,
   input wire       cp_gain_high, gm_gain_high
);
   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Manual codes override the thresholds one edge later
   a_sel_line: assert property (
      auto_clock_sel == 2'h0 |=> clock_mode == 3'h1) else $error("no line");
   a_sel_frame: assert property (
      auto_clock_sel == 2'h1 |=> clock_mode == 3'h2) else $error("no frame");
   a_sel_fixed: assert property (
      auto_clock_sel == 2'h2 |=> clock_mode == 3'h4) else $error("no fixed");
   // Without a field tick the automatic mode must hold
   a_tick_hold: assert property (
      auto_clock_sel == 2'h3 && !field_tick |=> $stable(clock_mode))
      else $error("mode moved without tick");
   // Line lock only climbs to frame lock, fixed only drops to line lock
   a_line_not_fixed: assert property (
      auto_clock_sel == 2'h3 && clock_mode == 3'h1 |=> clock_mode != 3'h4)
      else $error("line jumped to fixed");
   a_fixed_not_frame: assert property (
      auto_clock_sel == 2'h3 && clock_mode == 3'h4 |=> clock_mode != 3'h2)
      else $error("fixed jumped to frame");
   a_mode_onehot: assert property ($onehot(clock_mode))
      else $error("mode not one-hot");
   a_gain_codes: assert property (
      $onehot(frame_lock_ec_gain) && $onehot(line_lock_loop_gain))
      else $error("gain code out of set");
   // Data line may only move while the bus clock is low
   a_sda_scl_low: assert property ($changed(sda_oe_n) |-> !scl)
      else $error("data moved with clock high");
   // Open drain: the data pin only ever pulls low
   a_sda_drive_low: assert property (sda_out == 1'b0)
      else $error("data pin driven high");
   c_auto_frame: cover property (auto_clock_sel == 2'h3 && clock_mode == 3'h2);
   c_auto_fixed: cover property (auto_clock_sel == 2'h3 && clock_mode == 3'h4);
   c_ack: cover property ($fell(sda_oe_n));
endmodule // acm_clock_mode_checker

bind acm_clock_mode acm_clock_mode_checker acm_clock_mode_checker_inst (
   .clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe_n(sda_oe_n), .addr_sel(addr_sel), .auto_clock_sel(auto_clock_sel),
   .field_tick(field_tick), .lock_metric(lock_metric),
   .clock_mode(clock_mode), .frame_lock_ec_gain(frame_lock_ec_gain),
   .line_lock_loop_gain(line_lock_loop_gain), .cp_gain_high(cp_gain_high),
   .gm_gain_high(gm_gain_high));

// File: bench/acm_bus_host.sv
// Two-wire bus host model that programs and reads the registers
`timescale 1ns/1ps
module acm_bus_host (
   // Clock and bus lines
   input  wire clk,
   input  wire sda,
   output reg  scl,
   output reg  sda_rel
);
   // ****************************************
   // Bus cycles
   // ****************************************
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end
   // Six clocks a phase so the device synchroniser settles in time
   task ph;
      repeat (6) @(negedge clk);
   endtask
   task start;
      sda_rel = 1'b1;
      ph;
      scl = 1'b1;
      ph;
      sda_rel = 1'b0;
      ph;
      scl = 1'b0;
      ph;
   endtask
   task stop;
      sda_rel = 1'b0;
      ph;
      scl = 1'b1;
      ph;
      sda_rel = 1'b1;
      ph;
   endtask
   // Data changes only while the clock is low
   task bitx(input b, output r);
      sda_rel = b;
      ph;
      scl = 1'b1;
      ph;
      r = sda;
      scl = 1'b0;
      ph;
   endtask
   task xbyte(input [7:0] d, input a, output [7:0] q, output r);
      integer i;
      for (i = 7; i >= 0; i--) bitx(d[i], q[i]);
      bitx(a, r);
   endtask
   // ok is high only if every address or data byte was acknowledged
   task wr(input [6:0] dev, input [7:0] s, input [7:0] d, output ok);
      reg [7:0] q;
      reg r0, r1, r2;
      start;
      xbyte({dev, 1'b0}, 1'b1, q, r0);
      xbyte(s, 1'b1, q, r1);
      xbyte(d, 1'b1, q, r2);
      stop;
      ok = !(r0 | r1 | r2);
   endtask
   task rd(input [6:0] dev, input [7:0] s, output [7:0] q, output ok);
      reg r0, r1, r2, r3;
      start;
      xbyte({dev, 1'b0}, 1'b1, q, r0);
      xbyte(s, 1'b1, q, r1);
      start;
      xbyte({dev, 1'b1}, 1'b1, q, r2);
      xbyte(8'hff, 1'b1, q, r3);
      stop;
      ok = !(r0 | r1 | r2);
   endtask
endmodule // acm_bus_host

// File: bench/tb_top.sv
// Self-checking bench for the clock-mode block
`timescale 1ns/1ps
`include "acm_defs.vh"
module tb_top;
   reg        clk, rst_n, addr_sel, field_tick, ok;
   reg  [1:0] auto_clock_sel;
   reg  [7:0] lock_metric, q, prev;
   reg  [7:0] t [0:3];
   reg  [2:0] em;
   wire       scl, sda_rel, sda_out, sda_oe_n, cp_gain_high, gm_gain_high;
   wire       sda = sda_rel & (sda_oe_n | sda_out);
   wire [2:0] clock_mode;
   wire [3:0] frame_lock_ec_gain, line_lock_loop_gain;
   wire [6:0] dev = {`ACM_BUS_ADDR_HI, addr_sel};
   integer    error_cnt, tests_run, seed, i;
   localparam [31:0] RV = {`ACM_LINE_TO_FRAME_RST, `ACM_FRAME_TO_LINE_RST,
                           `ACM_FRAME_TO_FIXED_RST, `ACM_FIXED_TO_LINE_RST};
   localparam [15:0] LG = 16'h4812; // Line gain in half units per code
   // ****************************************
   // Design, host and helpers
   // ****************************************
   acm_clock_mode acm_clock_mode_inst (.clk(clk), .rst_n(rst_n), .scl(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
      .addr_sel(addr_sel), .auto_clock_sel(auto_clock_sel),
      .field_tick(field_tick), .lock_metric(lock_metric),
      .clock_mode(clock_mode), .frame_lock_ec_gain(frame_lock_ec_gain),
      .line_lock_loop_gain(line_lock_loop_gain),
      .cp_gain_high(cp_gain_high), .gm_gain_high(gm_gain_high));
   acm_bus_host acm_bus_host_inst (.clk(clk), .sda(sda), .scl(scl),
      .sda_rel(sda_rel));
   task chk(input [7:0] got, input [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Later tests win, so a drop to line lock beats a climb to fixed
   function [2:0] nm(input [2:0] m, input [7:0] p, input [7:0] c);
      nm = m;
      if (m == 3'h1 && p <= t[0] && c > t[0]) nm = 3'h2;
      if (m == 3'h2 && p <= t[2] && c > t[2]) nm = 3'h4;
      if (m == 3'h2 && p >= t[1] && c < t[1]) nm = 3'h1;
      if (m == 3'h4 && p >= t[3] && c < t[3]) nm = 3'h1;
   endfunction
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (100000) @(posedge clk);
      error_cnt++;
      end_sim;
   end
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      {rst_n, addr_sel, field_tick, auto_clock_sel, lock_metric} = 0;
      seed = 71;
      error_cnt = 0;
      tests_run = 0;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      // Wrong slave address is refused and leaves the register alone
      acm_bus_host_inst.wr(dev ^ 7'h01, 8'h46, 8'hff, ok);
      chk({7'h0, ok}, 8'h00);
      acm_bus_host_inst.rd(dev, `ACM_PLL_LOOP_CTRL_ADDR, q, ok);
      chk(q, `ACM_PLL_LOOP_CTRL_RST);
      acm_bus_host_inst.rd(dev, 8'h50, q, ok);
      chk(q, 8'h00);
      // Threshold reset values, then random values written and read back
      for (i = 0; i < 4; i++) begin
         acm_bus_host_inst.rd(dev, 8'(8'h37 + i), q, ok);
         chk(q, RV[31 - 8 * i -: 8]);
         t[i] = 8'($random(seed));
         acm_bus_host_inst.wr(dev, 8'(8'h37 + i), t[i], ok);
         acm_bus_host_inst.rd(dev, 8'(8'h37 + i), q, ok);
         chk(q, t[i]);
      end
      // Every gain code, manual pump bits and the spare top bit
      for (i = 0; i < 4; i++) begin
         acm_bus_host_inst.wr(dev, 8'h46, 8'(i * 21 + 128), ok);
         acm_bus_host_inst.rd(dev, 8'h46, q, ok);
         chk(q, 8'(i * 21 + 128));
         chk({4'h0, frame_lock_ec_gain}, 8'(1 << i));
         chk({4'h0, line_lock_loop_gain}, {4'h0, LG[4 * i +: 4]});
         chk({6'h0, cp_gain_high, gm_gain_high}, {6'h0, i[0], i[1]});
      end
      // Auto pump gain follows the mode whatever the manual bits say
      acm_bus_host_inst.wr(dev, 8'h46, 8'h70, ok);
      for (i = 0; i < 3; i++) begin
         auto_clock_sel = 2'(i);
         repeat (2) @(negedge clk);
         chk({5'h0, clock_mode}, 8'(1 << i));
         chk({6'h0, cp_gain_high, gm_gain_high}, i == 1 ? 8'h03 : 8'h00);
      end
      auto_clock_sel = 2'h0;
      @(negedge clk);
      auto_clock_sel = 2'h3;
      em = 3'h1;
      prev = 8'h00;
      // Random metric with ticks often back to back
      for (i = 0; i < 600; i++) begin
         @(negedge clk);
         chk({5'h0, clock_mode}, {5'h0, em});
         field_tick = 1'($random(seed));
         lock_metric = 8'($random(seed));
         if (field_tick) begin
            em = nm(em, prev, lock_metric);
            prev = lock_metric;
         end
      end
      // Let the last tick land, then freeze the metric path
      @(negedge clk);
      field_tick = 1'b0;
      chk({5'h0, clock_mode}, {5'h0, em});
      // Mode status is read-only: a write is acked but changes nothing
      acm_bus_host_inst.wr(dev, `ACM_MODE_STATUS_ADDR, 8'hff, ok);
      chk({7'h0, ok}, 8'h01);
      acm_bus_host_inst.rd(dev, `ACM_MODE_STATUS_ADDR, q, ok);
      chk(q, {5'h0, em});
      end_sim;
   end
endmodule // tb_top
